// file: fbp_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_cpu_model
	import fbp_pkg::*;
(
	input wire logic sys_clk,
	output logic [15:0] cpu_addr,
	output logic [7:0] cpu_wdata,
	output logic cpu_wr,
	output logic cpu_rd,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rhit
);
	// Bus idles with strobes low from time zero
	initial
	begin
		cpu_addr = FBP_ADDR_RST;
		cpu_wdata = 8'h00;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
	end

	// One write strobe per call, launched just after an edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge sys_clk);
		cpu_wr <= 1'b0;
	endtask

	// Answer is registered, so it is taken one step after the taking edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic hit);
		@(posedge sys_clk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge sys_clk);
		cpu_rd <= 1'b0;
		#1;
		d = cpu_rdata;
		hit = cpu_rhit;
	endtask

	// Select, protect byte read, address latch, then high voltage
	task automatic arm(input logic [7:0] ctl, input logic [15:0] a);
		logic [7:0] d;
		logic h;
		wr(FBP_CTL_ADDR, ctl);
		rd(FBP_PSB_ADDR, d, h);
		wr(a, 8'h00);
		wr(FBP_CTL_ADDR, ctl | 8'h08);
	endtask

	// Selects drop before the pump, as the sequence requires
	task automatic finish();
		wr(FBP_CTL_ADDR, 8'h08);
		wr(FBP_CTL_ADDR, 8'h00);
	endtask
endmodule
`default_nettype wire

// file: fbp_flash_protect.sv
// Functional notes
// - Programming is confined to one 32-byte row latched by the first write.
// - High-voltage enable is refused when the latched address is protected under the erase and mass bits held before the enabling write.
// - Protect byte all ones leaves the whole array open.
// - Any other value locks protected pages and the protect byte itself.
// - Detected high test voltage bypasses all block protection.
// - Protect byte is array storage, changed only by program or erase, not reset.
// - Start address is ones, protect byte as bits 13..6, then zeros.
// - Protection starts on a 64-byte page and runs to top of memory.
// - Protect byte value 80 hex protects the whole array.
// - Wait during read mode changes nothing in the flash.
// - Wait turns the charge pump off but keeps select and enable bits.
// - Stop during read mode puts the flash into standby.
// - Stop during program or erase abandons it and enters standby.
// - Standby holds every flash control signal inactive.
// - High-voltage enable sets only with a select bit and correct access order.
// - Erased bits read one, programmed bits zero, protect byte included.
`timescale 1ns/10ps
`default_nettype none
module fbp_flash_protect
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	output logic cpu_rhit,
	input wire logic high_test_voltage,
	input wire logic wait_mode,
	input wire logic stop_mode,
	output logic arr_hv_on,
	output logic arr_prog,
	output logic arr_erase,
	output logic arr_mass,
	output logic arr_standby,
	output logic arr_wr,
	output logic [15:0] arr_addr,
	output logic [7:0] arr_wdata,
	output logic [fbp_pkg::FBP_ROW_IDX_W-1:0] arr_idx
);
	import fbp_pkg::*;

	typedef struct packed {
		logic program_select;
		logic erase;
		logic mass;
		logic high_voltage_enable;
		fbp_state_type state;
		logic [15:0] lat_addr;
		logic [10:0] row_addr;
		logic vhi_meta;
		logic vhi_sync;
		logic [7:0] rdata;
		logic rhit;
		logic arr_hv_on;
		logic arr_prog;
		logic arr_erase;
		logic arr_mass;
		logic arr_standby;
		logic arr_wr;
		logic [15:0] arr_addr;
	} fbp_regs_type;

	fbp_regs_type s;
	fbp_regs_type n;
	logic [7:0] protect_start_byte;
	logic psb_prog_en;
	logic psb_erase_en;
	logic prot_c;
	logic hv_allowed_c;
	logic hv_grant;
	logic array_wr;
	fbp_row_if row ();

	// Start of the protected range for a given protect byte
	function automatic logic [15:0] fbp_start(input logic [7:0] psb);
		fbp_start = {FBP_START_TOP, psb, FBP_START_LOW};
	endfunction

	// Protection test on an address; erase covers the whole page
	function automatic logic fbp_protected(input logic [15:0] addr,
		input logic [7:0] psb, input logic erase, input logic mass);
		logic page_psb;
		page_psb = addr[15:FBP_PAGE_LSB] == FBP_PSB_ADDR[15:FBP_PAGE_LSB];
		if (psb == FBP_PSB_ERASED)
			fbp_protected = 1'b0;
		else if (mass)
			fbp_protected = 1'b1;
		else if (addr >= fbp_start(psb))
			fbp_protected = 1'b1;
		else if (erase ? page_psb : (addr == FBP_PSB_ADDR))
			fbp_protected = 1'b1;
		else
			fbp_protected = 1'b0;
	endfunction

	fbp_row_buf u_row
	(
		.sys_clk(sys_clk),
		.row(row)
	);

	// Decisions on the latched address and the synchronised detect; array write decode uses the live bus
	always_comb
	begin
		prot_c = fbp_protected(s.lat_addr, protect_start_byte, s.erase, s.mass);
		hv_allowed_c = !prot_c || s.vhi_sync;
		array_wr = cpu_wr && cpu_addr >= FBP_ARRAY_LO && cpu_addr != FBP_CTL_ADDR;
	end

	// Next state of everything but the nonvolatile protect byte
	always_comb
	begin
		n = s;
		hv_grant = 1'b0;
		psb_prog_en = 1'b0;
		psb_erase_en = 1'b0;
		row.we = 1'b0;
		row.idx = cpu_addr[FBP_ROW_IDX_W-1:0];
		row.wdata = cpu_wdata;
		n.vhi_meta = high_test_voltage;
		n.vhi_sync = s.vhi_meta;
		n.rhit = 1'b0;
		n.arr_wr = 1'b0;
		// Control register write; select bits interlock
		if (cpu_wr && cpu_addr == FBP_CTL_ADDR)
		begin
			if (!(cpu_wdata[FBP_PGM_BIT] && cpu_wdata[FBP_ERASE_BIT]))
			begin
				n.program_select = cpu_wdata[FBP_PGM_BIT];
				n.erase = cpu_wdata[FBP_ERASE_BIT];
			end
			n.mass = cpu_wdata[FBP_MASS_BIT];
			if (!cpu_wdata[FBP_HIGH_VOLTAGE_ENABLE_BIT])
				n.high_voltage_enable = 1'b0;
			else if (!s.high_voltage_enable && (n.program_select || n.erase) && s.state == FBP_ARMED && hv_allowed_c)
			begin
				// Granted only after select, protect read and address latch
				n.high_voltage_enable = 1'b1;
				hv_grant = 1'b1;
			end
		end
		// Erase of the protect byte takes effect when the pump is granted
		psb_erase_en = hv_grant && n.erase &&
			(n.mass || s.lat_addr[15:FBP_PAGE_LSB] == FBP_PSB_ADDR[15:FBP_PAGE_LSB]);
		// Access order tracking
		case (s.state)
			FBP_READ:
			begin
				if (n.program_select || n.erase)
					n.state = FBP_SEL;
			end
			FBP_SEL:
			begin
				if (cpu_rd && cpu_addr == FBP_PSB_ADDR)
					n.state = FBP_PSB_SEEN;
			end
			FBP_PSB_SEEN:
			begin
				if (array_wr)
				begin
					n.lat_addr = cpu_addr;
					n.row_addr = cpu_addr[15:FBP_ROW_IDX_W];
					n.state = FBP_ARMED;
				end
			end
			FBP_ARMED:
			begin
				if (hv_grant)
					n.state = FBP_HV;
			end
			FBP_HV:
			begin
				// Programming writes inside the latched row only; pump must run
				if (array_wr && s.program_select && s.high_voltage_enable && !wait_mode &&
					cpu_addr[15:FBP_ROW_IDX_W] == s.row_addr)
				begin
					row.we = 1'b1;
					n.arr_wr = 1'b1;
					n.arr_addr = cpu_addr;
					psb_prog_en = cpu_addr == FBP_PSB_ADDR &&
						(protect_start_byte == FBP_PSB_ERASED || s.vhi_sync);
				end
			end
			default:
			begin
				n.state = FBP_READ;
			end
		endcase
		if (!n.program_select && !n.erase && !n.high_voltage_enable)
			n.state = FBP_READ;
		// Stop drops any operation; the flash goes quiet
		if (stop_mode)
		begin
			n.program_select = 1'b0;
			n.erase = 1'b0;
			n.mass = 1'b0;
			n.high_voltage_enable = 1'b0;
			n.state = FBP_READ;
			n.arr_wr = 1'b0;
			row.we = 1'b0;
			psb_prog_en = 1'b0;
			psb_erase_en = 1'b0;
		end
		// Register reads
		if (cpu_rd && cpu_addr == FBP_CTL_ADDR)
		begin
			n.rdata = 8'h00;
			n.rdata[FBP_PGM_BIT] = s.program_select;
			n.rdata[FBP_ERASE_BIT] = s.erase;
			n.rdata[FBP_MASS_BIT] = s.mass;
			n.rdata[FBP_HIGH_VOLTAGE_ENABLE_BIT] = s.high_voltage_enable;
			n.rhit = 1'b1;
		end
		else if (cpu_rd && cpu_addr == FBP_PSB_ADDR)
		begin
			n.rdata = protect_start_byte;
			n.rhit = 1'b1;
		end
		// Wait gates the pump here and the program writes above; bits and read mode stay as they are
		n.arr_hv_on = n.high_voltage_enable && !wait_mode && !stop_mode;
		n.arr_prog = n.program_select && !stop_mode;
		n.arr_erase = n.erase && !stop_mode;
		n.arr_mass = n.mass && !stop_mode;
		n.arr_standby = stop_mode;
	end

	// Control state register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s.program_select <= 1'b0;
			s.erase <= 1'b0;
			s.mass <= 1'b0;
			s.high_voltage_enable <= 1'b0;
			s.state <= FBP_READ;
			s.lat_addr <= FBP_ADDR_RST;
			s.row_addr <= FBP_ADDR_RST[15:FBP_ROW_IDX_W];
			s.vhi_meta <= 1'b0;
			s.vhi_sync <= 1'b0;
			s.rdata <= FBP_RDATA_RST;
			s.rhit <= 1'b0;
			s.arr_hv_on <= 1'b0;
			s.arr_prog <= 1'b0;
			s.arr_erase <= 1'b0;
			s.arr_mass <= 1'b0;
			s.arr_standby <= 1'b0;
			s.arr_wr <= 1'b0;
			s.arr_addr <= FBP_ADDR_RST;
		end
		else
		begin
			s <= n;
		end
	end

	// Nonvolatile byte: no reset, so reset can never disturb the protection
	always_ff @(posedge sys_clk)
	begin
		if (psb_erase_en)
			protect_start_byte <= FBP_PSB_ERASED;
		else if (psb_prog_en)
			protect_start_byte <= protect_start_byte & cpu_wdata;
	end

	assign cpu_rdata = s.rdata;
	assign cpu_rhit = s.rhit;
	assign arr_hv_on = s.arr_hv_on;
	assign arr_prog = s.arr_prog;
	assign arr_erase = s.arr_erase;
	assign arr_mass = s.arr_mass;
	assign arr_standby = s.arr_standby;
	assign arr_wr = s.arr_wr;
	assign arr_addr = s.arr_addr;
	assign arr_wdata = row.rdata;
	assign arr_idx = s.arr_addr[FBP_ROW_IDX_W-1:0];

	// Array writes stay in the latched row
	property p_row_bound;
		@(posedge sys_clk) disable iff (!rst_n)
		s.arr_wr |-> s.arr_addr[15:FBP_ROW_IDX_W] == s.row_addr && arr_wdata == $past(cpu_wdata);
	endproperty
	a_row_bound: assert property (p_row_bound) else $error("array write outside latched row");

	// Pump enable only when allowed one cycle earlier
	property p_hv_refused;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(s.high_voltage_enable) |-> $past(hv_allowed_c);
	endproperty
	a_hv_refused: assert property (p_hv_refused) else $error("enable set on protected address");

	// Enable needs the full access order
	property p_order;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(s.high_voltage_enable) |-> $past(s.state) == FBP_ARMED && s.state == FBP_HV && (s.program_select || s.erase);
	endproperty
	a_order: assert property (p_order) else $error("enable set out of order");

	// Erased protect byte leaves everything open
	property p_open;
		@(posedge sys_clk) disable iff (!rst_n)
		protect_start_byte == FBP_PSB_ERASED |-> !prot_c;
	endproperty
	a_open: assert property (p_open) else $error("protection with erased byte");

	// Value 80 hex covers the whole array
	property p_all_prot;
		@(posedge sys_clk) disable iff (!rst_n)
		protect_start_byte == FBP_PSB_ALL && s.lat_addr >= FBP_ARRAY_LO |-> prot_c;
	endproperty
	a_all_prot: assert property (p_all_prot) else $error("array not fully protected");

	// Protect byte reprogrammed only when open or bypassed
	property p_psb_lock;
		@(posedge sys_clk) disable iff (!rst_n)
		psb_prog_en |-> protect_start_byte == FBP_PSB_ERASED || s.vhi_sync;
	endproperty
	a_psb_lock: assert property (p_psb_lock) else $error("locked protect byte programmed");

	// Wait turns the pump off and holds the enable
	property p_wait_pump;
		@(posedge sys_clk) disable iff (!rst_n)
		wait_mode && s.high_voltage_enable && !stop_mode && !cpu_wr |=> !s.arr_hv_on && s.high_voltage_enable;
	endproperty
	a_wait_pump: assert property (p_wait_pump) else $error("pump running in wait");

	// Stop abandons operations and enters standby
	property p_stop;
		@(posedge sys_clk) disable iff (!rst_n)
		stop_mode |=> s.arr_standby && !s.high_voltage_enable && !s.program_select && !s.erase && s.state == FBP_READ;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not reach standby");

	// Standby keeps all controls quiet
	property p_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		s.arr_standby |-> !(s.arr_prog || s.arr_erase || s.arr_mass || s.arr_hv_on || s.arr_wr);
	endproperty
	a_quiet: assert property (p_quiet) else $error("control active in standby");

	// Detect reaches decisions two edges after the pin
	property p_sync;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(s.vhi_sync) |-> $past(high_test_voltage, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("detect not synchronised");
endmodule
`default_nettype wire

// file: fbp_pkg.sv
package fbp_pkg;
	// Addresses seen by the CPU
	localparam logic [15:0] FBP_CTL_ADDR = 16'hfe08;
	localparam logic [15:0] FBP_PSB_ADDR = 16'hff7e;
	localparam logic [15:0] FBP_ARRAY_LO = 16'he000;
	// Flash control register bit positions
	localparam int FBP_PGM_BIT = 0;
	localparam int FBP_ERASE_BIT = 1;
	localparam int FBP_MASS_BIT = 2;
	localparam int FBP_HIGH_VOLTAGE_ENABLE_BIT = 3;
	// Row and page geometry
	localparam int FBP_ROW_BYTES = 32;
	localparam int FBP_ROW_IDX_W = 5;
	localparam int FBP_PAGE_LSB = 6;
	// Protect byte values
	localparam logic [7:0] FBP_PSB_ERASED = 8'hff;
	localparam logic [7:0] FBP_PSB_ALL = 8'h80;
	localparam logic [1:0] FBP_START_TOP = 2'h3;
	localparam logic [5:0] FBP_START_LOW = 6'h00;
	// Reset values
	localparam logic [7:0] FBP_RDATA_RST = 8'h00;
	localparam logic [15:0] FBP_ADDR_RST = 16'h0000;

	typedef enum logic [2:0] {
		FBP_READ = 3'b000,
		FBP_SEL = 3'b001,
		FBP_PSB_SEEN = 3'b010,
		FBP_ARMED = 3'b011,
		FBP_HV = 3'b100
	} fbp_state_type;
endpackage

// file: fbp_row_buf.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_row_buf
(
	input wire logic sys_clk,
	fbp_row_if.mem row
);
	import fbp_pkg::*;

	logic [7:0] mem_q [FBP_ROW_BYTES];
	logic [7:0] rd_q;

	// Row latch; no reset, contents are rewritten before every use
	always_ff @(posedge sys_clk)
	begin
		if (row.we)
		begin
			mem_q[row.idx] <= row.wdata;
		end
		// Written byte bypasses the array so the pulse sees it next cycle
		rd_q <= row.we ? row.wdata : mem_q[row.idx];
	end

	assign row.rdata = rd_q;
endmodule
`default_nettype wire

// file: fbp_row_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fbp_row_if;
	import fbp_pkg::*;
	logic we;
	logic [FBP_ROW_IDX_W-1:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output we, output idx, output wdata, input rdata);
	modport mem (input we, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// file: flash_block_protection_bench.sv
`timescale 1ns/10ps
`default_nettype none
module flash_block_protection_bench;
	import fbp_pkg::*;
	logic sys_clk, rst_n, hv, wt, st;
	logic [15:0] cpu_addr, arr_addr;
	logic [7:0] cpu_wdata, cpu_rdata, arr_wdata, d;
	logic cpu_wr, cpu_rd, cpu_rhit, h;
	logic arr_hv_on, arr_prog, arr_erase, arr_mass, arr_standby, arr_wr;
	logic [FBP_ROW_IDX_W-1:0] arr_idx;
	int miscompares = 0;
	int total_checks = 0;

	fbp_cpu_model cpu (.sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rhit(cpu_rhit));

	fbp_flash_protect dut (.sys_clk(sys_clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
		.cpu_rhit(cpu_rhit), .high_test_voltage(hv), .wait_mode(wt), .stop_mode(st),
		.arr_hv_on(arr_hv_on), .arr_prog(arr_prog), .arr_erase(arr_erase),
		.arr_mass(arr_mass), .arr_standby(arr_standby), .arr_wr(arr_wr),
		.arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_idx(arr_idx));

	// Free-running 125 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Detect input passes two sync flops, so let it settle before use
	task automatic set_hv(input logic v);
		@(posedge sys_clk);
		hv <= v;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic arm_chk(input logic [7:0] ctl, input logic [15:0] a, input logic e);
		cpu.arm(ctl, a);
		@(posedge sys_clk);
		#1;
		check(arr_hv_on, e);
	endtask

	// Program write; the array pulse is registered at the taking edge and checked just after it
	task automatic pwr(input logic [15:0] a, input logic [7:0] v, input logic e);
		cpu.wr(a, v);
		#1;
		check(arr_wr, e);
		if (e)
		begin
			check(arr_addr, a);
			check({arr_wdata, 3'h0, arr_idx}, {v, 3'h0, a[4:0]});
		end
	endtask

	task automatic psb_chk(input logic [7:0] e);
		cpu.rd(FBP_PSB_ADDR, d, h);
		check({h, d}, {1'b1, e});
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		miscompares++;
		test_done();
	end

	initial
	begin
		rst_n = 1'b0;
		hv = 1'b0;
		wt = 1'b0;
		st = 1'b0;
		do_reset();
		#1;
		check({arr_hv_on, arr_prog, arr_erase, arr_mass, arr_wr}, 16'h0000);
		// Protect byte has no reset value: bypass and mass-erase it first
		set_hv(1'b1);
		arm_chk(8'h06, FBP_ARRAY_LO, 1'b1);
		check({arr_prog, arr_erase, arr_mass}, 16'h0003);
		// Control readback: erase, mass and enable set, program clear
		cpu.rd(FBP_CTL_ADDR, d, h);
		check({h, d}, {1'b1, 8'h0e});
		cpu.finish();
		set_hv(1'b0);
		psb_chk(FBP_PSB_ERASED);
		$display("test erase done");
		// Erased byte leaves everything open, including the byte itself
		arm_chk(8'h01, 16'hff60, 1'b1);
		pwr(FBP_PSB_ADDR, 8'h81, 1'b1);
		cpu.finish();
		psb_chk(8'h81);
		$display("test program byte done");
		// Skipping the protect byte read must keep the pump off
		cpu.wr(FBP_CTL_ADDR, 8'h01);
		cpu.wr(16'he020, 8'h00);
		cpu.wr(FBP_CTL_ADDR, 8'h09);
		@(posedge sys_clk);
		#1;
		check(arr_hv_on, 1'b0);
		cpu.finish();
		// Start is e040: just below is open, other rows of the latch are ignored
		arm_chk(8'h01, 16'he020, 1'b1);
		pwr(16'he005, 8'h5a, 1'b0);
		pwr(16'he03f, 8'ha5, 1'b1);
		cpu.finish();
		arm_chk(8'h01, 16'he040, 1'b0);
		cpu.finish();
		arm_chk(8'h02, 16'hff40, 1'b0);
		cpu.finish();
		arm_chk(8'h01, 16'hffc0, 1'b0);
		cpu.finish();
		$display("test protect range done");
		// Detect opens the protected byte again
		set_hv(1'b1);
		arm_chk(8'h01, 16'he040, 1'b1);
		cpu.finish();
		arm_chk(8'h01, 16'hff60, 1'b1);
		pwr(FBP_PSB_ADDR, FBP_PSB_ALL, 1'b1);
		cpu.finish();
		set_hv(1'b0);
		psb_chk(FBP_PSB_ALL);
		arm_chk(8'h01, FBP_ARRAY_LO, 1'b0);
		cpu.finish();
		$display("test whole array done");
		// Wait in mid-program: pump off, bits kept, leave by reset
		set_hv(1'b1);
		// Wait from read mode leaves the flash as it is
		@(posedge sys_clk);
		wt <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check({arr_standby, arr_hv_on, arr_prog}, 16'h0000);
		@(posedge sys_clk);
		wt <= 1'b0;
		arm_chk(8'h01, FBP_ARRAY_LO, 1'b1);
		@(posedge sys_clk);
		wt <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check({arr_hv_on, arr_prog}, 16'h0001);
		do_reset();
		wt <= 1'b0;
		#1;
		check({arr_hv_on, arr_prog}, 16'h0000);
		psb_chk(FBP_PSB_ALL);
		$display("test wait done");
		// Stop in mid-program abandons it into standby
		arm_chk(8'h01, FBP_ARRAY_LO, 1'b1);
		@(posedge sys_clk);
		st <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check({arr_standby, arr_hv_on, arr_prog, arr_erase, arr_mass}, 16'h0010);
		@(posedge sys_clk);
		st <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		check({arr_standby, arr_hv_on, arr_prog}, 16'h0000);
		// Stop again from read mode
		@(posedge sys_clk);
		st <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check(arr_standby, 1'b1);
		st <= 1'b0;
		set_hv(1'b0);
		$display("test stop done");
		test_done();
	end
endmodule
`default_nettype wire
